// File: logic/aed_pkg.sv
// Package of constants for the axis error detector.
// Assumes a single 125 MHz controller clock and no software register bus.
package aed_pkg;

  // Error codes reported on the status output
  localparam logic [15:0] AED_CODE_NONE        = 16'h0000;
  localparam logic [15:0] AED_CODE_DATA_ILL    = 16'h004a;
  localparam logic [15:0] AED_CODE_POS_OVF     = 16'h004d;
  localparam logic [15:0] AED_CODE_ROT_RANGE   = 16'h004e;
  localparam logic [15:0] AED_CODE_ENC_POWER   = 16'h004f;
  localparam logic [15:0] AED_CODE_PRX_LIM     = 16'h0052;
  localparam logic [15:0] AED_CODE_LIM_START   = 16'h0053;
  localparam logic [15:0] AED_CODE_LIM_REVERSE = 16'h0054;

  // Numeric limits
  localparam int          AED_ROT_LIMIT_HARD   = 99999;
  localparam int          AED_ROT_LIMIT_SOFT   = 99998;
  localparam logic [31:0] AED_POS_MAX          = 32'h7fffffff;

  // Stop methods
  localparam logic [1:0]  AED_STOP_NONE        = 2'h0;
  localparam logic [1:0]  AED_STOP_DECEL       = 2'h1;
  localparam logic [1:0]  AED_STOP_ACCUM       = 2'h2;

  // Latch states, one-hot
  typedef enum logic [1:0] {
    AED_ST_IDLE  = 2'b01,
    AED_ST_ERROR = 2'b10
  } aed_state_t;

endpackage : aed_pkg

// File: logic/aed_code_reg.sv
// Holding register for the latched error code and stop method.
// Assumes the caller gives load and clear as single-cycle qualifiers.
`timescale 1ns/1ps
`default_nettype none
module aed_code_reg
  import aed_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic        clear,
  input  wire logic [15:0] code_in,
  input  wire logic [1:0]  stop_in,
  output logic      [15:0] code_ff,
  output logic      [1:0]  stop_ff
);

  // Load wins over clear so a fresh error is not lost
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      code_ff <= AED_CODE_NONE;
      stop_ff <= AED_STOP_NONE;
    end
    else if (ce && load)
    begin
      code_ff <= code_in;
      stop_ff <= stop_in;
    end
    else if (ce && clear)
    begin
      code_ff <= AED_CODE_NONE;
      stop_ff <= AED_STOP_NONE;
    end
  end

endmodule : aed_code_reg
`default_nettype wire

// File: logic/aed_axis_error_detector.sv
// Axis error detector: encoder, counter and origin-search checks.
// Assumes all inputs synchronous to clk; the encoder and sensors sit outside.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Valid, fault-free encoder data flagged illegal gives code 004A and a deceleration stop.
// - Present position counter going past 2147483647 gives code 004D and an accumulated-pulse stop.
// - Setting position from the encoder with rotations beyond +-99999 gives 004E and decel stop.
// - Rotations within +-99998 whose corrected sum overflows the counter also give 004E.
// - Encoder supply loss or internal fault gives code 004F and a deceleration stop.
// - Proximity and search-direction limit both on during a search gives 0052 and decel stop.
// - Search-direction limit on at start of a one-direction search gives 0053 and decel stop.
// - Search-direction limit on while a reverse search reverses on proximity gives 0054.
module aed_axis_error_detector
  import aed_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               ce,
  input  wire logic               enc_data_valid,
  input  wire logic               enc_comm_fault,
  input  wire logic               encoder_data_illegal,
  input  wire logic               encoder_power_fault,
  input  wire logic               pos_step,
  input  wire logic               pos_dir_neg,
  input  wire logic               pos_set_req,
  input  wire logic signed [31:0] rot_count,
  input  wire logic signed [31:0] rot_correction,
  input  wire logic               search_active,
  input  wire logic               search_start,
  input  wire logic               search_one_dir,
  input  wire logic               search_reversing,
  input  wire logic               origin_proximity,
  input  wire logic               search_limit,
  input  wire logic               error_clear,
  output logic                    error_ff,
  output logic             [15:0] error_code_ff,
  output logic             [1:0]  stop_method_ff,
  output logic                    motion_allow_ff,
  output logic signed      [31:0] position_ff
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Magnitude test against a symmetric limit
  function automatic logic beyond(input logic signed [31:0] v, input int lim);
    beyond = (v > 32'(lim)) || (v < -32'(lim));
  endfunction : beyond

  ////////////////////////////////////////////////////////////////////////
  // Detection

  logic signed [32:0] corr_sum;
  logic signed [32:0] sum_max;
  logic               pos_load;
  logic               pos_at_max;
  logic               pos_at_min;
  logic               ev_data;
  logic               ev_ovf;
  logic               ev_rot;
  logic               ev_power;
  logic               ev_prx;
  logic               ev_start;
  logic               ev_rev;
  logic               any_ev;
  logic [15:0]        ev_code;
  logic [1:0]         ev_stop;
  logic               latch_clear;
  aed_state_t         state_ff;
  aed_state_t         nxt_state;
  logic               nxt_error;
  logic               nxt_allow;
  logic signed [31:0] nxt_position;
  logic [15:0]        held_code;
  logic [1:0]         held_stop;

  // Corrected rotation sum, one extra bit to see overflow
  assign corr_sum   = 33'(rot_count) + 33'(rot_correction);
  assign sum_max    = $signed({1'b0, AED_POS_MAX});
  assign pos_at_max = (position_ff == $signed(AED_POS_MAX));
  assign pos_at_min = (position_ff == -$signed(AED_POS_MAX));

  // Individual error events
  assign ev_data  = enc_data_valid && !enc_comm_fault && encoder_data_illegal;
  assign ev_ovf   = pos_step && (pos_dir_neg ? pos_at_min : pos_at_max);
  assign ev_rot   = pos_set_req && (beyond(rot_count, AED_ROT_LIMIT_HARD)
                 || (!beyond(rot_count, AED_ROT_LIMIT_SOFT)
                     && (corr_sum > sum_max || corr_sum < -sum_max)));
  assign ev_power = encoder_power_fault;
  assign ev_prx   = search_active && origin_proximity && search_limit;
  assign ev_start = search_start && search_one_dir && search_limit;
  assign ev_rev   = search_active && search_reversing && search_limit
                 && !origin_proximity;
  assign any_ev   = ev_data | ev_ovf | ev_rot | ev_power | ev_prx | ev_start | ev_rev;

  // Priority encode: supply fault first, search faults last
  assign ev_code = ev_power ? AED_CODE_ENC_POWER   :
                   ev_data  ? AED_CODE_DATA_ILL    :
                   ev_ovf   ? AED_CODE_POS_OVF     :
                   ev_rot   ? AED_CODE_ROT_RANGE   :
                   ev_prx   ? AED_CODE_PRX_LIM     :
                   ev_start ? AED_CODE_LIM_START   :
                              AED_CODE_LIM_REVERSE;
  assign ev_stop = (ev_ovf && !ev_power && !ev_data) ? AED_STOP_ACCUM : AED_STOP_DECEL;

  ////////////////////////////////////////////////////////////////////////
  // Latch

  assign latch_clear = error_clear && !any_ev;

  // Error latch state, set wins over clear
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      AED_ST_IDLE:  if (any_ev) nxt_state = AED_ST_ERROR;
      AED_ST_ERROR: if (latch_clear) nxt_state = AED_ST_IDLE;
      default:      nxt_state = AED_ST_IDLE;
    endcase
  end

  assign nxt_error = (nxt_state == AED_ST_ERROR);
  assign nxt_allow = !nxt_error;

  // Position counter: a clean encoder set loads the corrected sum, else steps count
  assign pos_load     = pos_set_req && !any_ev && state_ff == AED_ST_IDLE;
  assign nxt_position = pos_load ? corr_sum[31:0]
                      : (pos_step && !ev_ovf && state_ff == AED_ST_IDLE)
                        ? (pos_dir_neg ? position_ff - 32'sd1 : position_ff + 32'sd1)
                        : position_ff;

  // Held code register
  aed_code_reg u_code
  (
    .clk     (clk),
    .resetn  (resetn),
    .ce      (ce),
    .load    (any_ev),
    .clear   (latch_clear),
    .code_in (ev_code),
    .stop_in (ev_stop),
    .code_ff (held_code),
    .stop_ff (held_stop)
  );

  // State and output flops
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_ff        <= AED_ST_IDLE;
      error_ff        <= 1'b0;
      motion_allow_ff <= 1'b1;
      position_ff     <= '0;
    end
    else if (ce)
    begin
      state_ff        <= nxt_state;
      error_ff        <= nxt_error;
      motion_allow_ff <= nxt_allow;
      position_ff     <= nxt_position;
    end
  end

  // Code outputs mirror the holding register
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      error_code_ff  <= AED_CODE_NONE;
      stop_method_ff <= AED_STOP_NONE;
    end
    else if (ce)
    begin
      error_code_ff  <= held_code;
      stop_method_ff <= held_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // Event taken on an enabled edge, outputs allowed to move on the next
  sequence s_taken(logic ev);
    (ce && ev) ##1 ce;
  endsequence

  // Held code and stop method visible one edge later
  sequence s_code_seen(logic [15:0] c, logic [1:0] m);
    ##1 (error_code_ff == c && stop_method_ff == m);
  endsequence

  a_data_illegal: assert property (@(posedge clk) disable iff (!resetn)
    s_taken(ev_data && !ev_power) |-> s_code_seen(AED_CODE_DATA_ILL, AED_STOP_DECEL))
    else $error("illegal data code missing");

  a_ovf_accum: assert property (@(posedge clk) disable iff (!resetn)
    s_taken(ev_ovf && !ev_power && !ev_data)
      |-> s_code_seen(AED_CODE_POS_OVF, AED_STOP_ACCUM))
    else $error("overflow stop method wrong");

  a_ovf_hold: assert property (@(posedge clk) disable iff (!resetn)
    (ce && ev_ovf) |=> (position_ff == $past(position_ff)))
    else $error("counter moved past limit");

  a_rot_range: assert property (@(posedge clk) disable iff (!resetn)
    s_taken(pos_set_req && beyond(rot_count, AED_ROT_LIMIT_HARD) && !ev_power && !ev_data
      && !ev_ovf) |-> s_code_seen(AED_CODE_ROT_RANGE, AED_STOP_DECEL))
    else $error("rotation range code missing");

  a_rot_sum: assert property (@(posedge clk) disable iff (!resetn)
    (ce && pos_set_req && rot_count <= AED_ROT_LIMIT_SOFT && rot_count >= -AED_ROT_LIMIT_SOFT
      && ((longint'(rot_count) + longint'(rot_correction) > longint'(AED_POS_MAX))
      || (longint'(rot_count) + longint'(rot_correction) < -longint'(AED_POS_MAX))))
      |=> error_ff)
    else $error("corrected sum overflow missed");

  a_power_fault: assert property (@(posedge clk) disable iff (!resetn)
    s_taken(encoder_power_fault) |-> s_code_seen(AED_CODE_ENC_POWER, AED_STOP_DECEL))
    else $error("power fault code missing");

  a_prx_limit: assert property (@(posedge clk) disable iff (!resetn)
    (ce && search_active && origin_proximity && search_limit) |=> error_ff)
    else $error("proximity with limit not flagged");

  a_limit_start: assert property (@(posedge clk) disable iff (!resetn)
    s_taken(ev_start && !ev_power && !ev_data && !ev_ovf && !ev_rot && !ev_prx)
      |-> s_code_seen(AED_CODE_LIM_START, AED_STOP_DECEL))
    else $error("limit at start code missing");

  a_limit_rev: assert property (@(posedge clk) disable iff (!resetn)
    s_taken(ev_rev && !ev_power && !ev_data && !ev_ovf && !ev_rot && !ev_start)
      |-> s_code_seen(AED_CODE_LIM_REVERSE, AED_STOP_DECEL))
    else $error("reverse limit code missing");

  a_motion_block: assert property (@(posedge clk) disable iff (!resetn)
    error_ff |-> !motion_allow_ff)
    else $error("motion allowed with error latched");

  a_step_refused: assert property (@(posedge clk) disable iff (!resetn)
    error_ff |=> (position_ff == $past(position_ff)))
    else $error("position moved with error latched");

endmodule : aed_axis_error_detector
`default_nettype wire

// File: sim/aed_partner.sv
// Far-side model: absolute encoder, limit and proximity sensors.
// Assumes the bench names per cycle which levels it wants shown.
`timescale 1ns/1ps
`default_nettype none
module aed_partner
(
  input  wire logic               clk,
  input  wire logic [5:0]         want,
  input  wire logic               use_rot,
  input  wire logic signed [31:0] want_rot,
  input  wire logic signed [31:0] want_corr,
  output logic                    enc_data_valid,
  output logic                    enc_comm_fault,
  output logic                    encoder_data_illegal,
  output logic                    encoder_power_fault,
  output logic                    origin_proximity,
  output logic                    search_limit,
  output logic signed [31:0]      rot_count,
  output logic signed [31:0]      rot_correction
);
  logic [31:0] junk_ff = 32'h5a5a5a5a;

  // Unqualified rotation lines toggle every cycle
  always @(posedge clk)
  begin
    junk_ff <= ~junk_ff;
  end

  // Encoder word flags and sensor levels
  assign enc_data_valid       = want[0];
  assign enc_comm_fault       = want[1];
  assign encoder_data_illegal = want[2];
  assign encoder_power_fault  = want[3];
  assign origin_proximity     = want[4];
  assign search_limit         = want[5];
  assign rot_count            = use_rot ? want_rot : junk_ff;
  assign rot_correction       = use_rot ? want_corr : ~junk_ff;
endmodule : aed_partner
`default_nettype wire

// File: sim/tb.sv
// Bench for the axis error detector with a cycle model.
// Assumes the partner model drives encoder and sensor inputs.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import aed_pkg::*;
  logic clk = 0, resetn = 0, ce = 1, go = 0, use_rot = 0, m_err, ovf;
  logic pos_step = 0, pos_dir_neg = 0, pos_set_req = 0, error_clear = 0;
  logic search_active = 0, search_start = 0, search_one_dir = 0, search_reversing = 0;
  logic enc_data_valid, enc_comm_fault, encoder_data_illegal, encoder_power_fault;
  logic origin_proximity, search_limit, error_ff, motion_allow_ff;
  logic [5:0] want = 6'h00;
  logic signed [31:0] want_rot = 32'h0, want_corr = 32'h0, rot_count, rot_correction;
  logic signed [31:0] position_ff;
  logic [15:0] error_code_ff, m_cp, m_code, e, lf;
  logic [1:0] stop_method_ff, m_sp, m_stop;
  logic [15:0] codes [7] = '{AED_CODE_ENC_POWER, AED_CODE_DATA_ILL, AED_CODE_ROT_RANGE,
    AED_CODE_ROT_RANGE, AED_CODE_PRX_LIM, AED_CODE_LIM_START, AED_CODE_LIM_REVERSE};
  int m_pos, n_fail = 0, comparisons = 0;

  aed_axis_error_detector aed_axis_error_detector_i (.clk(clk), .resetn(resetn), .ce(ce),
    .enc_data_valid(enc_data_valid), .enc_comm_fault(enc_comm_fault),
    .encoder_data_illegal(encoder_data_illegal), .encoder_power_fault(encoder_power_fault),
    .pos_step(pos_step), .pos_dir_neg(pos_dir_neg), .pos_set_req(pos_set_req),
    .rot_count(rot_count), .rot_correction(rot_correction), .search_active(search_active),
    .search_start(search_start), .search_one_dir(search_one_dir),
    .search_reversing(search_reversing), .origin_proximity(origin_proximity),
    .search_limit(search_limit), .error_clear(error_clear), .error_ff(error_ff),
    .error_code_ff(error_code_ff), .stop_method_ff(stop_method_ff),
    .motion_allow_ff(motion_allow_ff), .position_ff(position_ff));
  aed_partner aed_partner_i (.clk(clk), .want(want), .use_rot(use_rot), .want_rot(want_rot),
    .want_corr(want_corr), .enc_data_valid(enc_data_valid), .enc_comm_fault(enc_comm_fault),
    .encoder_data_illegal(encoder_data_illegal), .encoder_power_fault(encoder_power_fault),
    .origin_proximity(origin_proximity), .search_limit(search_limit),
    .rot_count(rot_count), .rot_correction(rot_correction));

  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic bit bad_set(input longint r, input longint c);
    return r > AED_ROT_LIMIT_HARD || r < -AED_ROT_LIMIT_HARD || (r <= AED_ROT_LIMIT_SOFT
      && r >= -AED_ROT_LIMIT_SOFT && (r + c > 64'sh7fffffff || r + c < -64'sh7fffffff));
  endfunction : bad_set

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic idle;
    {want, use_rot, pos_set_req, search_active, search_start} = 0;
    {search_one_dir, search_reversing, pos_step, error_clear, ce} = 5'h01;
  endtask : idle

  ////////////////////////////////////////////////////////////////////////////
  // Cycle model: event priority, latch, two-stage code, position count
  always @(posedge clk)
  begin
    ovf = pos_step && (pos_dir_neg ? m_pos == -2147483647 : m_pos == 2147483647);
    e = 16'h0000;
    if (want[3]) e = AED_CODE_ENC_POWER;
    else if (want[0] && !want[1] && want[2]) e = AED_CODE_DATA_ILL;
    else if (ovf) e = AED_CODE_POS_OVF;
    else if (pos_set_req && bad_set(rot_count, rot_correction)) e = AED_CODE_ROT_RANGE;
    else if (search_active && want[4] && want[5]) e = AED_CODE_PRX_LIM;
    else if (search_start && search_one_dir && want[5]) e = AED_CODE_LIM_START;
    else if (search_active && search_reversing && want[5]) e = AED_CODE_LIM_REVERSE;
    if (!resetn)
      {m_err, m_cp, m_code, m_sp, m_stop, m_pos} = 0;
    else if (ce)
    begin
      {m_code, m_stop} = {m_cp, m_sp};
      if (!m_err && pos_set_req && e == 16'h0000) m_pos = rot_count + rot_correction;
      else if (!m_err && pos_step && !ovf) m_pos += pos_dir_neg ? -1 : 1;
      if (e != 16'h0000)
        {m_err, m_cp, m_sp} = {1'b1, e,
          (e == AED_CODE_POS_OVF) ? AED_STOP_ACCUM : AED_STOP_DECEL};
      else if (error_clear) {m_err, m_cp, m_sp} = 0;
    end
  end

  // Every output against the model, every cycle
  always @(negedge clk)
    if (go)
    begin
      chk("error", error_ff, m_err);
      chk("allow", motion_allow_ff, !m_err);
      chk("code", error_code_ff, m_code);
      chk("stop", stop_method_ff, m_stop);
      chk("position", position_ff, m_pos);
    end

  // Watchdog
  initial
  begin
    repeat (2000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    lf = 16'h3974;
    tick();
    go = 1;
    repeat (4) tick();
    resetn = 1;
    // Random steps count the position
    repeat (40)
    begin
      lf = lfsr(lf);
      {pos_dir_neg, pos_step} = lf[1:0];
      tick();
    end
    // Each error kind but overflow: latch, steps refused, clear
    for (int k = 0; k < 7; k++)
    begin
      idle();
      lf = lfsr(lf);
      use_rot = 1;
      want_rot = (k == 2) ? 32'h186a0 + lf : AED_ROT_LIMIT_SOFT;
      want_corr = 32'h7fffffff - lf;
      case (k)
        0: want = 6'h08;
        1: want = 6'h05;
        2, 3: pos_set_req = 1;
        4: {search_active, want} = 7'h70;
        5: {search_active, search_start, search_one_dir, want} = 9'h1e0;
        default: {search_active, search_reversing, want} = 8'he0;
      endcase
      tick();
      idle();
      pos_step = 1;
      tick();
      chk("kind", error_code_ff, codes[k]);
      chk("method", stop_method_ff, AED_STOP_DECEL);
      {pos_step, error_clear} = 2'h1;
      tick();
      idle();
      repeat (2) tick();
      chk("cleared", error_code_ff, AED_CODE_NONE);
    end
    // Encoder set near the top, two up steps: the second overflows
    idle();
    lf = lfsr(lf);
    {use_rot, pos_set_req} = 2'h3;
    want_rot = {24'h0, lf[7:0]};
    want_corr = 32'h7ffffffe - want_rot;
    tick();
    idle();
    pos_step = 1;
    repeat (2) tick();
    pos_step = 0;
    tick();
    chk("overflow", error_code_ff, AED_CODE_POS_OVF);
    chk("accumulated", stop_method_ff, AED_STOP_ACCUM);
    chk("top", position_ff, 32'h7fffffff);
    // Mid-run reset drops the latch and the count
    resetn = 0;
    tick();
    resetn = 1;
    tick();
    chk("after reset", error_ff, 1'b0);
    // Faulty word, frozen cycle, then clear refused beside events
    want = 6'h07;
    tick();
    {ce, want} = 7'h08;
    tick();
    idle();
    repeat (2) tick();
    chk("quiet", error_ff, 1'b0);
    {want, error_clear} = 7'h1d;
    tick();
    idle();
    repeat (2) tick();
    chk("first", error_code_ff, AED_CODE_ENC_POWER);
    error_clear = 1;
    tick();
    idle();
    repeat (2) tick();
    stop_test();
  end
endmodule : tb
`default_nettype wire
